// *** design/pfsr_map.vh ***
// register offsets, field positions and reset values for the port fault status bank
`ifndef PFSR_MAP_VH
`define PFSR_MAP_VH
`define PFSR_OFF_P1_LOAD     8'h00
`define PFSR_OFF_P2_LOAD     8'h01
`define PFSR_OFF_ALERT_CC    8'h02
`define PFSR_OFF_P1_FAULT    8'h03
`define PFSR_BIT_P2_ALERT    7
`define PFSR_BIT_P1_ALERT    6
`define PFSR_BIT_P2_CC       5
`define PFSR_BIT_P1_CC       4
`define PFSR_BIT_ERR         7
`define PFSR_BIT_DISCH       6
`define PFSR_BIT_RESET       5
`define PFSR_BIT_KEEPOUT     4
`define PFSR_BIT_OVTEMP      3
`define PFSR_BIT_OVSUPPLY    2
`define PFSR_BIT_BACKBIAS    1
`define PFSR_BIT_OVCURR      0
`define PFSR_LOAD_RST        8'h00
`define PFSR_FAULT_RST       8'h20
`define PFSR_LSB_UA          13300
`define PFSR_FULL_CODE       8'hFF
`define PFSR_BACKBIAS_MV     150
`endif

// *** design/pfsr_regs.v ***
// port fault status register bank: load current, alert/cc status, port 1 fault flags
`timescale 1ns/1ps
`include "pfsr_map.vh"
module pfsr_regs #(
    parameter CODE_W = 8
) (
    input  wire              sys_clk_i,
    input  wire              sys_rst_i,
    input  wire [7:0]        reg_addr_i,
    input  wire              reg_rd_i,
    input  wire              reg_wr_i,
    input  wire [7:0]        reg_wdata_i,
    output reg  [7:0]        reg_rdata_o,
    output reg               reg_rvalid_o,
    input  wire              sleep_i,
    input  wire              active_i,
    input  wire [CODE_W-1:0] port1_adc_code_i,
    input  wire [CODE_W-1:0] port2_adc_code_i,
    input  wire              port1_switch_on_i,
    input  wire              port2_switch_on_i,
    input  wire              port1_discharging_i,
    input  wire              port2_discharging_i,
    input  wire              port1_const_current_i,
    input  wire              port2_const_current_i,
    input  wire              port1_alert_n_pin_i,
    input  wire              port2_alert_n_pin_i,
    input  wire              port1_power_enable_i,
    input  wire              auto_recovery_i,
    input  wire              port1_discharge_fail_i,
    input  wire              port1_undervolt_keepout_i,
    input  wire              overtemp_high_i,
    input  wire              supply_overvoltage_i,
    input  wire              port1_backbias_i,
    input  wire              port1_overcurrent_i,
    output reg               port1_alert_req_o,
    output reg               port2_alert_req_o,
    output reg               port1_error_state_o
);

    // synchronisers for all asynchronous status inputs
    localparam NSYNC = 16;
    wire [NSYNC-1:0] async_in = {port1_switch_on_i, port2_switch_on_i, port1_discharging_i, port2_discharging_i,
                                 port1_const_current_i, port2_const_current_i, port1_alert_n_pin_i,
                                 port2_alert_n_pin_i, port1_power_enable_i, sleep_i,
                                 port1_discharge_fail_i, port1_undervolt_keepout_i, overtemp_high_i,
                                 supply_overvoltage_i, port1_backbias_i, port1_overcurrent_i};
    reg  [NSYNC-1:0] sync1_r;
    reg  [NSYNC-1:0] sync2_r;
    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_r <= {NSYNC{1'b0}};
            sync2_r <= {NSYNC{1'b0}};
        end else begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
        end
    end
    wire p1_sw      = sync2_r[15];
    wire p2_sw      = sync2_r[14];
    wire p1_dis     = sync2_r[13];
    wire p2_dis     = sync2_r[12];
    wire p1_cc      = sync2_r[11];
    wire p2_cc      = sync2_r[10];
    wire p1_alert_n = sync2_r[9];
    wire p2_alert_n = sync2_r[8];
    wire p1_pwr_en  = sync2_r[7];
    wire sleep_s    = sync2_r[6];
    wire [5:0] cond = sync2_r[5:0];

    reg        sleep_d_r;
    reg        pwr_en_d_r;
    // the synchroniser leaves reset at 0 while the enable pin may idle high, so edges
    // are ignored until both sync stages and the delay stage hold real pin values
    reg  [1:0] settle_r;
    wire       settled = (settle_r == 2'h3);
    reg [CODE_W-1:0] p1_code_r;
    reg [CODE_W-1:0] p2_code_r;
    reg [7:0]  flags_r;
    reg [7:0]  flags_nxt;
    reg [7:0]  status_r;
    reg [7:0]  rd_data_nxt;
    reg        err_nxt;

    wire sleep_entry = sleep_s & ~sleep_d_r;
    wire pwr_toggle  = settled & (p1_pwr_en ^ pwr_en_d_r);
    wire pwr_fall    = settled & pwr_en_d_r & ~p1_pwr_en;
    wire rd_fault    = reg_rd_i & (reg_addr_i == `PFSR_OFF_P1_FAULT);
    wire wr_err0     = reg_wr_i & (reg_addr_i == `PFSR_OFF_P1_FAULT) & ~reg_wdata_i[`PFSR_BIT_ERR];
    wire any_cond    = |cond;
    wire [5:0] other_flags = {flags_r[`PFSR_BIT_DISCH], flags_r[`PFSR_BIT_KEEPOUT], flags_r[`PFSR_BIT_OVTEMP],
                              flags_r[`PFSR_BIT_OVSUPPLY], flags_r[`PFSR_BIT_BACKBIAS], flags_r[`PFSR_BIT_OVCURR]};
    // reset flag counts as a set bit too: error is held until it is read away or power enable toggles
    wire others_set  = (|other_flags) | flags_r[`PFSR_BIT_RESET];

    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sleep_d_r  <= 1'b0;
            pwr_en_d_r <= 1'b0;
            settle_r   <= 2'h0;
        end else begin
            sleep_d_r  <= sleep_s;
            pwr_en_d_r <= p1_pwr_en;
            if (!settled) begin
                settle_r <= settle_r + 2'h1;
            end
        end
    end

    // code is stored raw: one LSB per 13.3 mA, 255 at full scale, unsigned
    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            p1_code_r <= `PFSR_LOAD_RST;
            p2_code_r <= `PFSR_LOAD_RST;
        end else begin
            if (sleep_entry || sleep_s) begin
                p1_code_r <= `PFSR_LOAD_RST;
            end else if (!p1_sw || p1_dis) begin
                p1_code_r <= `PFSR_LOAD_RST;
            end else if (active_i) begin
                p1_code_r <= port1_adc_code_i;
            end
            if (sleep_entry || sleep_s) begin
                p2_code_r <= `PFSR_LOAD_RST;
            end else if (!p2_sw || p2_dis) begin
                p2_code_r <= `PFSR_LOAD_RST;
            end else if (active_i) begin
                p2_code_r <= port2_adc_code_i;
            end
        end
    end

    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status_r <= 8'h00;
        end else begin
            status_r <= {~p2_alert_n, ~p1_alert_n, p2_cc, p1_cc, 4'h0};
        end
    end

    // fault flags: set wins over any clear in the same cycle
    always @* begin
        flags_nxt = flags_r;
        err_nxt   = flags_r[`PFSR_BIT_ERR];
        if (rd_fault) begin
            // read returns old value this cycle; stale conditions and the reset flag clear
            flags_nxt[`PFSR_BIT_DISCH]    = flags_r[`PFSR_BIT_DISCH]    & cond[5];
            flags_nxt[`PFSR_BIT_KEEPOUT]  = flags_r[`PFSR_BIT_KEEPOUT]  & cond[4];
            flags_nxt[`PFSR_BIT_OVTEMP]   = flags_r[`PFSR_BIT_OVTEMP]   & cond[3];
            flags_nxt[`PFSR_BIT_OVSUPPLY] = flags_r[`PFSR_BIT_OVSUPPLY] & cond[2];
            flags_nxt[`PFSR_BIT_BACKBIAS] = flags_r[`PFSR_BIT_BACKBIAS] & cond[1];
            flags_nxt[`PFSR_BIT_OVCURR]   = flags_r[`PFSR_BIT_OVCURR]   & cond[0];
            flags_nxt[`PFSR_BIT_RESET]    = 1'b0;
        end
        if (pwr_toggle) begin
            flags_nxt[`PFSR_BIT_RESET] = 1'b0;
        end
        if (wr_err0 && !any_cond && !others_set) begin
            err_nxt = 1'b0;
        end
        if (auto_recovery_i && !any_cond && !others_set) begin
            err_nxt = 1'b0;
        end
        if (pwr_fall) begin
            err_nxt = 1'b0;
        end
        if (flags_r[`PFSR_BIT_ERR] && !err_nxt) begin
            flags_nxt[6] = 1'b0;
            flags_nxt[4:0] = 5'h00;
        end
        flags_nxt[`PFSR_BIT_DISCH]    = flags_nxt[`PFSR_BIT_DISCH]    | cond[5];
        flags_nxt[`PFSR_BIT_KEEPOUT]  = flags_nxt[`PFSR_BIT_KEEPOUT]  | cond[4];
        flags_nxt[`PFSR_BIT_OVTEMP]   = flags_nxt[`PFSR_BIT_OVTEMP]   | cond[3];
        flags_nxt[`PFSR_BIT_OVSUPPLY] = flags_nxt[`PFSR_BIT_OVSUPPLY] | cond[2];
        flags_nxt[`PFSR_BIT_BACKBIAS] = flags_nxt[`PFSR_BIT_BACKBIAS] | cond[1];
        flags_nxt[`PFSR_BIT_OVCURR]   = flags_nxt[`PFSR_BIT_OVCURR]   | cond[0];
        if (any_cond) begin
            err_nxt = 1'b1;
        end
        flags_nxt[`PFSR_BIT_ERR] = err_nxt;
    end

    // reset value sets the power-up flag; sleep does not touch flags
    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_r <= `PFSR_FAULT_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // alert requests follow latched flags and live conditions, not the error bit, so software can
    // clear a stuck error without forcing the pin
    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            port1_alert_req_o   <= 1'b0;
            port2_alert_req_o   <= 1'b0;
            port1_error_state_o <= 1'b0;
        end else begin
            port1_alert_req_o   <= |other_flags | any_cond;
            port2_alert_req_o   <= flags_r[`PFSR_BIT_OVTEMP] | flags_r[`PFSR_BIT_OVSUPPLY] | cond[3] | cond[2];
            port1_error_state_o <= flags_nxt[`PFSR_BIT_ERR];
        end
    end

    always @* begin
        case (reg_addr_i)
            `PFSR_OFF_P1_LOAD:  rd_data_nxt = p1_code_r;
            `PFSR_OFF_P2_LOAD:  rd_data_nxt = p2_code_r;
            `PFSR_OFF_ALERT_CC: rd_data_nxt = status_r;
            `PFSR_OFF_P1_FAULT: rd_data_nxt = flags_r;
            default:            rd_data_nxt = 8'h00;
        endcase
    end

    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rd_data_nxt;
            end
        end
    end

endmodule // pfsr_regs

// *** test/pfsr_regs_chk.sv ***
// assertions on the port fault status bank ports
`timescale 1ns/1ps
module pfsr_chk (
    input wire       sys_clk_i,
    input wire       sys_rst_i,
    input wire [7:0] reg_addr_i,
    input wire       reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire       reg_rvalid_o,
    input wire       port1_const_current_i,
    input wire       port2_const_current_i,
    input wire       port1_alert_n_pin_i,
    input wire       port2_alert_n_pin_i,
    input wire       port1_power_enable_i,
    input wire       overtemp_high_i,
    input wire       supply_overvoltage_i,
    input wire       port1_overcurrent_i,
    input wire       port1_alert_req_o,
    input wire       port2_alert_req_o,
    input wire       port1_error_state_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire [3:0] sts_w;
    reg  [3:0] sts_r;
    reg  [2:0] calm_r;
    assign sts_w = {~port2_alert_n_pin_i, ~port1_alert_n_pin_i, port2_const_current_i, port1_const_current_i};
    // pins pass a synchroniser, so compare only once they have been still for a while
    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sts_r  <= 4'h0;
            calm_r <= 3'h0;
        end else begin
            sts_r  <= sts_w;
            calm_r <= (sts_w != sts_r) ? 3'h0 : (calm_r == 3'h7) ? calm_r : calm_r + 3'h1;
        end
    end
    a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
    a_no_stray_valid: assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("stray read valid");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 8'h03 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_status_mirror: assert property (reg_rd_i && reg_addr_i == 8'h02 && calm_r > 3'h3 && sts_w == sts_r
        |=> reg_rdata_o[7:4] == $past(sts_w)) else $error("status bits wrong");
    a_overcurrent_error: assert property ($rose(port1_overcurrent_i) ##0 (port1_overcurrent_i &&
        port1_power_enable_i)[*5] |-> port1_error_state_o && port1_alert_req_o) else $error("overcurrent missed");
    a_overtemp_alerts: assert property ($rose(overtemp_high_i) ##0 (overtemp_high_i && port1_power_enable_i)[*5]
        |-> port1_alert_req_o && port2_alert_req_o && port1_error_state_o) else $error("overtemp missed");
    a_port2_cause: assert property ($rose(port2_alert_req_o) |-> $past(overtemp_high_i, 2) ||
        $past(supply_overvoltage_i, 2)) else $error("port2 alert without cause");
    a_reset_quiet: assert property ($past(sys_rst_i) |-> !port1_alert_req_o && !port2_alert_req_o
        && !port1_error_state_o) else $error("alert right after reset");
endmodule // pfsr_chk
bind pfsr_regs pfsr_chk u_pfsr_chk (.sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
    .port1_const_current_i, .port2_const_current_i, .port1_alert_n_pin_i, .port2_alert_n_pin_i,
    .port1_power_enable_i, .overtemp_high_i, .supply_overvoltage_i, .port1_overcurrent_i, .port1_alert_req_o,
    .port2_alert_req_o, .port1_error_state_o);

// *** test/pfsr_host.sv ***
// register host model issuing single byte reads and writes
`timescale 1ns/1ps
module pfsr_host (
    input  wire       sys_clk_i,
    input  wire [7:0] reg_rdata_i,
    input  wire       reg_rvalid_i,
    output reg  [7:0] reg_addr_o = 8'h00,
    output reg        reg_rd_o = 1'b0,
    output reg        reg_wr_o = 1'b0,
    output reg  [7:0] reg_wdata_o = 8'h00
);
    task rd(input [7:0] a, output [7:0] d);
        integer n;
        begin
            @(posedge sys_clk_i);
            reg_addr_o <= a;
            reg_rd_o   <= 1'b1;
            @(posedge sys_clk_i);
            reg_rd_o   <= 1'b0;
            reg_addr_o <= ~a;
            #1;
            for (n = 0; n < 4 && reg_rvalid_i !== 1'b1; n = n + 1) begin
                @(posedge sys_clk_i);
                #1;
            end
            d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hXX;
            @(posedge sys_clk_i);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge sys_clk_i);
            reg_addr_o  <= a;
            reg_wdata_o <= d;
            reg_wr_o    <= 1'b1;
            @(posedge sys_clk_i);
            reg_wr_o    <= 1'b0;
            reg_addr_o  <= ~a;
            reg_wdata_o <= ~d;
        end
    endtask
endmodule // pfsr_host

// *** test/pfsr_regs_tb.sv ***
// self-checking testbench for the port fault status bank
`timescale 1ns/1ps
module pfsr_regs_tb;
    reg        clk = 1'b0, rst = 1'b1, slp = 1'b0, act = 1'b0, pen = 1'b1, arec = 1'b0;
    reg  [1:0] sw = 2'b00, dis = 2'b00, cc = 2'b00, aln = 2'b11;
    reg  [5:0] flt = 6'h00;
    reg  [7:0] p1c = 8'h00, p2c = 8'h00;
    wire [7:0] addr, wdata, rdata;
    wire       rd, wr, rvalid, al1, al2, err;
    integer    failures = 0, checked = 0;
    pfsr_host u_pfsr_host (.sys_clk_i(clk), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_addr_o(addr),
        .reg_rd_o(rd), .reg_wr_o(wr), .reg_wdata_o(wdata));
    pfsr_regs u_pfsr_regs (.sys_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .sleep_i(slp), .active_i(act),
        .port1_adc_code_i(p1c), .port2_adc_code_i(p2c), .port1_switch_on_i(sw[0]), .port2_switch_on_i(sw[1]),
        .port1_discharging_i(dis[0]), .port2_discharging_i(dis[1]), .port1_const_current_i(cc[0]),
        .port2_const_current_i(cc[1]), .port1_alert_n_pin_i(aln[0]), .port2_alert_n_pin_i(aln[1]),
        .port1_power_enable_i(pen), .auto_recovery_i(arec), .port1_discharge_fail_i(flt[5]),
        .port1_undervolt_keepout_i(flt[4]), .overtemp_high_i(flt[3]), .supply_overvoltage_i(flt[2]),
        .port1_backbias_i(flt[1]), .port1_overcurrent_i(flt[0]), .port1_alert_req_o(al1),
        .port2_alert_req_o(al2), .port1_error_state_o(err));
    initial begin
        forever #4 clk = ~clk;
    end
    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("unexpected %0s: expected %h, seen %h", nm, e, g);
            end
        end
    endtask
    task rdchk(input string nm, input [7:0] a, input [7:0] e, input [7:0] m);
        reg [7:0] d;
        begin
            u_pfsr_host.rd(a, d);
            chk(nm, e, d & m);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task t_power_up;
        begin
            rdchk("fault_flags", 8'h03, 8'h20, 8'hFF);
            rdchk("fault_flags", 8'h03, 8'h00, 8'hFF);
            u_pfsr_host.wr(8'h00, 8'hFF);
            rdchk("p1_load", 8'h00, 8'h00, 8'hFF);
            rdchk("unmapped", 8'h07, 8'h00, 8'hFF);
        end
    endtask
    task t_load;
        begin
            act <= 1'b1;
            sw <= 2'b11;
            p1c <= 8'hFF;
            p2c <= 8'h5A;
            tick(6);
            rdchk("p1_load", 8'h00, 8'hFF, 8'hFF);
            rdchk("p2_load", 8'h01, 8'h5A, 8'hFF);
            sw <= 2'b10;
            dis <= 2'b10;
            tick(6);
            rdchk("p1_load", 8'h00, 8'h00, 8'hFF);
            rdchk("p2_load", 8'h01, 8'h00, 8'hFF);
            sw <= 2'b11;
            dis <= 2'b00;
            slp <= 1'b1;
            tick(6);
            rdchk("p2_load", 8'h01, 8'h00, 8'hFF);
            slp <= 1'b0;
            p1c <= 8'h80;
            tick(6);
            rdchk("p1_load", 8'h00, 8'h80, 8'hFF);
        end
    endtask
    task t_status;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                aln <= i[1:0];
                cc <= {i[0], i[1]};
                tick(6);
                rdchk("status", 8'h02, {~i[1], ~i[0], i[0], i[1], 4'h0}, 8'hF0);
            end
            aln <= 2'b11;
            cc <= 2'b00;
        end
    endtask
    task t_faults;
        integer i;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                flt <= 6'h01 << i;
                tick(6);
                chk("error_state", 8'h01, {7'h0, err});
                chk("alert_req", {6'h0, i == 2 || i == 3, 1'b1}, {6'h0, al2, al1});
                flt <= 6'h00;
                tick(6);
                u_pfsr_host.wr(8'h03, 8'h00);
                tick(6);
                chk("error_held", 8'h01, {7'h0, err});
                rdchk("fault_flags", 8'h03, (i == 5) ? 8'hC0 : 8'h80 | (8'h01 << i), 8'hFF);
                u_pfsr_host.wr(8'h03, 8'h00);
                tick(6);
                rdchk("fault_flags", 8'h03, 8'h00, 8'hFF);
            end
        end
    endtask
    task t_recover;
        begin
            flt <= 6'h01;
            tick(6);
            flt <= 6'h00;
            pen <= 1'b0;
            tick(6);
            chk("error_state", 8'h00, {7'h0, err});
            pen <= 1'b1;
            flt <= 6'h02;
            tick(6);
            flt <= 6'h00;
            tick(6);
            rdchk("fault_flags", 8'h03, 8'h82, 8'hFF);
            arec <= 1'b1;
            tick(6);
            chk("error_state", 8'h00, {7'h0, err});
        end
    endtask
    task conclude;
        begin
            $display("checked %0d, failures %0d", checked, failures);
            if (failures == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        tick(6);
        rst <= 1'b0;
        t_power_up;
        t_load;
        t_status;
        t_faults;
        t_recover;
        conclude;
    end
    initial begin
        #200000;
        failures = failures + 1;
        conclude;
    end
endmodule // pfsr_regs_tb
